// File: common/rld_pkg.sv
// constants, types and helpers for the relay low-side driver control block
//
// Contract
// - six independent relay channels, each with own overcurrent protection and diagnosis.
// - each channel follows the on/off command written by the microcontroller.
// - device reset forces every channel off except a held channel one or two; global output disable forces every channel off.
// - channels one and two hold on from reset falling edge for 400-800 ms.
// - held channel switches off when hold time expires without microcontroller takeover.
// - hold applies only while the battery-low indication is active.
// - hold enabled per channel by two bits of config register seven.
// - overcurrent qualified after persisting 2 to 5 us, typically 4 us.
// - off-state open load and short to ground qualified after 35-65 us.
// - off-state diagnosis ignored for 300-500 us after switch-off.
// - qualified overcurrent turns channel off through the fast turn-off path.
// - 2-bit code per channel: 11 ok, 01 open, 10 overcurrent, 00 ground.
// - detected fault stays latched until the next diagnosis read clears it.
// - tripped channel restarts on command low-high, or at diagnosis read.
// - first off-state fault kept; only later on-state overcurrent overwrites it.
package rld_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NCH = 6;
  localparam int NHOLD = 2;
  localparam int AW = 8;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 200;
  localparam int OCUR_FILT_NS = 4000;
  localparam int DIAG_FILT_US = 50;
  localparam int BLANK_US = 400;
  localparam int HOLD_MS = 600;
  localparam int OCUR_FILT_CYC = (OCUR_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int DIAG_FILT_CYC = DIAG_FILT_US * CLK_MHZ;
  localparam int BLANK_CYC = BLANK_US * CLK_MHZ;
  localparam int HOLD_CYC = HOLD_MS * 1000 * CLK_MHZ;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [AW-1:0] REG_CMD = 8'h00;
  localparam logic [AW-1:0] REG_CTRL = 8'h04;
  localparam logic [AW-1:0] REG_CONF7 = 8'h08;
  localparam logic [AW-1:0] REG_DIAG = 8'h0C;
  localparam logic [AW-1:0] REG_STAT = 8'h10;
  localparam logic [NCH-1:0] CMD_RST = 6'h00;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [NHOLD-1:0] CONF7_RST = 2'h0;
  localparam int CTRL_DIS_BIT = 0;
  localparam int CONF7_EN_LSB = 0;
  localparam int STAT_RUN_LSB = 6;
  localparam int STAT_EXP_LSB = 8;

  // ****************************************
  // fault codes
  // ****************************************
  localparam logic [1:0] FC_OK = 2'h3;
  localparam logic [1:0] FC_OPEN = 2'h1;
  localparam logic [1:0] FC_SHORT_BAT = 2'h2;
  localparam logic [1:0] FC_SHORT_GND = 2'h0;

  typedef enum logic [1:0] {
    HOLD_IDLE = 2'b00,
    HOLD_RUN = 2'b01,
    HOLD_EXP = 2'b11
  } rld_hold_t;

  // off-state code from the low comparator
  function automatic logic [1:0] rld_off_code(input logic below_low);
    rld_off_code = below_low ? FC_SHORT_GND : FC_OPEN;
  endfunction : rld_off_code

endpackage : rld_pkg

// File: hw/rld_filt.sv
// persistence filter: hit once the condition held for CYC clocks
`timescale 1ns/1ps
module rld_filt #(
  parameter int unsigned CYC = 1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cond_i,
  output logic hit_o
);
  import rld_pkg::*;

  localparam int W = $clog2(CYC + 1);

  logic [W-1:0] cnt_q;

  // ****************************************
  // saturating persistence counter
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (reset_i || !cond_i) begin
      cnt_q <= '0;
    end else if (cnt_q != W'(CYC)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign hit_o = (cnt_q == W'(CYC));

endmodule : rld_filt

// File: hw/rld_ahb.sv
// zero-wait AHB-Lite slave front end for the relay control registers
`timescale 1ns/1ps
module rld_ahb (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [31:0] rdata_i,
  output logic rd_o,
  output logic [rld_pkg::AW-1:0] raddr_o,
  output logic wr_o,
  output logic [rld_pkg::AW-1:0] waddr_o,
  output logic [31:0] wdata_o
);
  import rld_pkg::*;

  logic acc;
  logic wr_q;
  logic [AW-1:0] waddr_q;
  logic [31:0] hrdata_q;

  // ****************************************
  // address phase
  // ****************************************
  assign acc = hsel_i & htrans_i[1] & hready_i;
  assign rd_o = acc & ~hwrite_i;
  assign raddr_o = haddr_i[AW-1:0];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_q <= 1'b0;
      waddr_q <= '0;
    end else begin
      wr_q <= acc & hwrite_i;
      if (acc) begin
        waddr_q <= haddr_i[AW-1:0];
      end
    end
  end

  // ****************************************
  // data phase
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_o) begin
      hrdata_q <= rdata_i;
    end
  end

  assign wr_o = wr_q;
  assign waddr_o = waddr_q;
  assign wdata_o = hwdata_i;
  assign hrdata_o = hrdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

endmodule : rld_ahb

// File: hw/rld_top.sv
// six-channel relay low-side driver control with diagnosis and low-battery hold
`timescale 1ns/1ps
module rld_top #(
  parameter int unsigned DIAG_FILT_CYC = rld_pkg::DIAG_FILT_CYC,
  parameter int unsigned BLANK_CYC = rld_pkg::BLANK_CYC,
  parameter int unsigned HOLD_CYC = rld_pkg::HOLD_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic device_reset_signal_n_i,
  input wire logic battery_low_level_i,
  input wire logic [rld_pkg::NCH-1:0] overcurrent_fault_i,
  input wire logic [rld_pkg::NCH-1:0] below_low_diag_threshold_i,
  input wire logic [rld_pkg::NCH-1:0] below_high_diag_threshold_i,
  output logic [rld_pkg::NCH-1:0] drive_on_o,
  output logic [rld_pkg::NCH-1:0] fast_off_o,
  output logic [rld_pkg::NHOLD-1:0] hold_active_o
);
  import rld_pkg::*;

  localparam int BW = $clog2(BLANK_CYC + 1);
  localparam int HW = $clog2(HOLD_CYC + 1);

  logic rd;
  logic wr;
  logic [AW-1:0] raddr;
  logic [AW-1:0] waddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic diag_rd;

  logic [NCH-1:0] cmd_q;
  logic outdis_q;
  logic [NHOLD-1:0] lb_en_q;
  logic devrst_n_q;
  logic rst_fall;

  logic [NCH-1:0] on_q;
  logic [NCH-1:0] on_d;
  logic [NCH-1:0] trip_q;
  logic [NCH-1:0] ocur_hit;
  logic [NCH-1:0] gnd_hit;
  logic [NCH-1:0] open_hit;
  logic [NCH-1:0] diag_en;
  logic [NCH-1:0][1:0] code_q;
  logic [NCH-1:0][BW-1:0] blank_q;

  rld_hold_t hold_q [NHOLD];
  logic [NHOLD-1:0][HW-1:0] hold_cnt_q;
  logic [NHOLD-1:0] hold_start;
  logic [NHOLD-1:0] hold_on;
  logic [NHOLD-1:0] hold_clr;
  logic [NHOLD-1:0] hold_run;
  logic [NHOLD-1:0] hold_exp;
  logic [NCH-1:0] hold_vec;
  logic [NCH-1:0] hold_clr_vec;

  // ****************************************
  // bus slave
  // ****************************************
  rld_ahb u_ahb (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hsize_i(hsize_i),
    .hready_i(hready_i),
    .hwdata_i(hwdata_i),
    .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .rdata_i(rdata),
    .rd_o(rd),
    .raddr_o(raddr),
    .wr_o(wr),
    .waddr_o(waddr),
    .wdata_o(wdata)
  );

  assign diag_rd = rd & (raddr == REG_DIAG);

  // ****************************************
  // command register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd_q <= CMD_RST;
    end else if (wr && (waddr == REG_CMD)) begin
      cmd_q <= wdata[NCH-1:0];
    end else begin
      cmd_q <= cmd_q & ~hold_clr_vec;
    end
  end

  // ****************************************
  // control and config register seven
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      outdis_q <= CTRL_RST;
    end else if (wr && (waddr == REG_CTRL)) begin
      outdis_q <= wdata[CTRL_DIS_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lb_en_q <= CONF7_RST;
    end else if (wr && (waddr == REG_CONF7)) begin
      lb_en_q <= wdata[CONF7_EN_LSB +: NHOLD];
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    case (raddr)
      REG_CMD: rdata = 32'(cmd_q);
      REG_CTRL: rdata = 32'(outdis_q);
      REG_CONF7: rdata = 32'(lb_en_q);
      REG_DIAG: rdata = 32'(code_q);
      REG_STAT: begin
        rdata = 32'(on_q);
        rdata[STAT_RUN_LSB +: NHOLD] = hold_run;
        rdata[STAT_EXP_LSB +: NHOLD] = hold_exp;
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // device reset edge
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      devrst_n_q <= 1'b1;
    end else begin
      devrst_n_q <= device_reset_signal_n_i;
    end
  end

  assign rst_fall = devrst_n_q & ~device_reset_signal_n_i;

  // ****************************************
  // low-battery hold
  // ****************************************
  for (genvar h = 0; h < NHOLD; h++) begin : g_hold
    assign hold_run[h] = (hold_q[h] == HOLD_RUN);
    assign hold_exp[h] = (hold_q[h] == HOLD_EXP);
    assign hold_start[h] = (hold_q[h] == HOLD_IDLE) & rst_fall & battery_low_level_i
                           & lb_en_q[h] & on_q[h];
    assign hold_clr[h] = hold_run[h] & (hold_cnt_q[h] == '0) & ~device_reset_signal_n_i
                         & battery_low_level_i;
    assign hold_on[h] = hold_start[h] | (hold_run[h] & ~hold_clr[h]);

    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        hold_q[h] <= HOLD_IDLE;
        hold_cnt_q[h] <= '0;
      end else begin
        case (hold_q[h])
          HOLD_IDLE: begin
            if (hold_start[h]) begin
              hold_q[h] <= HOLD_RUN;
              hold_cnt_q[h] <= HW'(HOLD_CYC - 1);
            end
          end
          HOLD_RUN: begin
            if (device_reset_signal_n_i || !battery_low_level_i) begin
              hold_q[h] <= HOLD_IDLE;
            end else if (hold_cnt_q[h] == '0) begin
              hold_q[h] <= HOLD_EXP;
            end else begin
              hold_cnt_q[h] <= hold_cnt_q[h] - 1'b1;
            end
          end
          HOLD_EXP: begin
            if (device_reset_signal_n_i) begin
              hold_q[h] <= HOLD_IDLE;
            end
          end
          default: hold_q[h] <= HOLD_IDLE;
        endcase
      end
    end
  end

  assign hold_vec = NCH'(hold_on);
  assign hold_clr_vec = NCH'(hold_clr);
  assign hold_active_o = hold_run;

  // ****************************************
  // per-channel switching and diagnosis
  // ****************************************
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign on_d[c] = ~outdis_q & ~trip_q[c]
                     & (hold_vec[c] | (cmd_q[c] & device_reset_signal_n_i));
    assign diag_en[c] = ~on_q[c] & (blank_q[c] == '0);

    rld_filt #(
      .CYC(OCUR_FILT_CYC)
    ) u_ocur (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .cond_i(overcurrent_fault_i[c] & on_q[c]),
      .hit_o(ocur_hit[c])
    );

    rld_filt #(
      .CYC(DIAG_FILT_CYC)
    ) u_gnd (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .cond_i(diag_en[c] & below_low_diag_threshold_i[c]),
      .hit_o(gnd_hit[c])
    );

    rld_filt #(
      .CYC(DIAG_FILT_CYC)
    ) u_open (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .cond_i(diag_en[c] & ~below_low_diag_threshold_i[c] & below_high_diag_threshold_i[c]),
      .hit_o(open_hit[c])
    );

    // output state
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        on_q[c] <= 1'b0;
      end else begin
        on_q[c] <= on_d[c];
      end
    end

    // overcurrent trip, set wins over restart
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        trip_q[c] <= 1'b0;
      end else if (ocur_hit[c]) begin
        trip_q[c] <= 1'b1;
      end else if (!cmd_q[c] || diag_rd) begin
        trip_q[c] <= 1'b0;
      end
    end

    // blanking after switch-off
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        blank_q[c] <= '0;
      end else if (on_q[c] && !on_d[c]) begin
        blank_q[c] <= BW'(BLANK_CYC);
      end else if (blank_q[c] != '0) begin
        blank_q[c] <= blank_q[c] - 1'b1;
      end
    end

    // fault latch, new fault wins over the read clear
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        code_q[c] <= FC_OK;
      end else if (ocur_hit[c] && !trip_q[c]) begin
        code_q[c] <= FC_SHORT_BAT;
      end else if ((gnd_hit[c] || open_hit[c]) && (code_q[c] == FC_OK || diag_rd)) begin
        code_q[c] <= rld_off_code(gnd_hit[c]);
      end else if (diag_rd) begin
        code_q[c] <= FC_OK;
      end
    end
  end

  // ****************************************
  // driver outputs
  // ****************************************
  assign drive_on_o = on_q;
  assign fast_off_o = trip_q;

endmodule : rld_top

// File: tb/rld_properties.sv
// concurrent checks on the relay driver control top
`timescale 1ns/1ps
module rld_properties #(
  parameter int unsigned DIAG_FILT_CYC = 20,
  parameter int unsigned BLANK_CYC = 30,
  parameter int unsigned HOLD_CYC = 200
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic device_reset_signal_n_i,
  input wire logic battery_low_level_i,
  input wire logic [rld_pkg::NCH-1:0] overcurrent_fault_i,
  input wire logic [rld_pkg::NCH-1:0] drive_on_o,
  input wire logic [rld_pkg::NCH-1:0] fast_off_o,
  input wire logic [rld_pkg::NHOLD-1:0] hold_active_o
);
  import rld_pkg::*;
  logic [9:0] ocur_q;
  logic [31:0] hold_q;
  // ****************************************
  // helper counters
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (reset_i || !overcurrent_fault_i[2]) begin
      ocur_q <= '0;
    end else if (ocur_q != 10'h3FF) begin
      ocur_q <= ocur_q + 10'h001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i || !hold_active_o[0]) begin
      hold_q <= '0;
    end else begin
      hold_q <= hold_q + 32'h0000_0001;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_reset_all_off: assert property (disable iff (1'b0) reset_i |=>
    drive_on_o == '0 && fast_off_o == '0 && hold_active_o == '0) else $error("on in reset");
  a_devrst_off: assert property (!device_reset_signal_n_i |=>
    drive_on_o[NCH-1:NHOLD] == '0) else $error("channel on in device reset");
  a_hold_lowbat: assert property (!battery_low_level_i |=>
    hold_active_o == '0) else $error("hold without low battery");
  a_hold_start: assert property ($rose(hold_active_o[0]) |->
    $past(battery_low_level_i) && !$past(device_reset_signal_n_i)) else $error("bad hold start");
  a_hold_bound: assert property (hold_q <= HOLD_CYC + 1)
    else $error("hold too long");
  a_hold_expire: assert property ($fell(hold_active_o[0]) && !device_reset_signal_n_i
    |-> ##[0:1] !drive_on_o[0]) else $error("held channel not off");
  a_trip_off: assert property ((fast_off_o & $past(fast_off_o) & drive_on_o) == '0)
    else $error("tripped channel on");
  a_ocur_filter: assert property ($rose(fast_off_o[2]) |-> ocur_q >= 10'h190)
    else $error("trip too early");
  cover property ($rose(fast_off_o[2]));
  cover property ($rose(hold_active_o[1]));
  cover property ($fell(hold_active_o[0]) && !device_reset_signal_n_i);
endmodule : rld_properties

// File: tb/rld_load_model.sv
// load and output comparator model for the relay channels
`timescale 1ns/1ps
module rld_load_model (
  input wire logic [rld_pkg::NCH-1:0] drive_on_i,
  input wire logic [2*rld_pkg::NCH-1:0] mode_i,
  output logic [rld_pkg::NCH-1:0] ocur_o,
  output logic [rld_pkg::NCH-1:0] below_low_o,
  output logic [rld_pkg::NCH-1:0] below_high_o
);
  import rld_pkg::*;
  // mode per channel uses the fault code of the load condition
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      ocur_o[c] = drive_on_i[c] && mode_i[2*c+:2] == FC_SHORT_BAT;
      below_low_o[c] = drive_on_i[c] || mode_i[2*c+:2] == FC_SHORT_GND;
      below_high_o[c] = below_low_o[c] || mode_i[2*c+:2] == FC_OPEN;
    end
  end
endmodule : rld_load_model

// File: tb/tb.sv
// self-checking testbench for the relay driver control top
`timescale 1ns/1ps
module tb;
  import rld_pkg::*;
  localparam int unsigned HC = 200;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hrdy;
  logic hresp;
  logic dev_n = 1'b1;
  logic bat_low = 1'b0;
  logic [11:0] mode = 12'hFFF;
  logic [5:0] ocur, blow, bhigh, drv, foff;
  logic [1:0] hact;
  logic [16:0] seed = 17'h1_7FA7;
  logic [31:0] rd;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int t0;
  rld_top #(.DIAG_FILT_CYC(20), .BLANK_CYC(30), .HOLD_CYC(HC)) i_rld_top (
    .clk_i(clk_i), .reset_i(reset_i), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hrdy),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
    .device_reset_signal_n_i(dev_n), .battery_low_level_i(bat_low),
    .overcurrent_fault_i(ocur), .below_low_diag_threshold_i(blow),
    .below_high_diag_threshold_i(bhigh), .drive_on_o(drv), .fast_off_o(foff),
    .hold_active_o(hact));
  rld_load_model i_rld_load_model (.drive_on_i(drv), .mode_i(mode), .ocur_o(ocur),
    .below_low_o(blow), .below_high_o(bhigh));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    lfsr = {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr
  function automatic logic [1:0] exp_off(input logic [1:0] m);
    exp_off = (m == FC_SHORT_BAT) ? FC_OK : m;
  endfunction : exp_off
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int a = 0; a < 24; a += 4) begin
      xfer(1'b0, a[7:0], 32'h0000_0000);
      chk("reset_reg", rd, (a == 12) ? 32'h0000_0FFF : 32'h0000_0000);
    end
    chk("okay", {hrdy, hresp}, 2'h2);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      xfer(1'b1, REG_CMD, {26'h000_0000, seed[5:0]});
      repeat (2) @(posedge clk_i);
      xfer(1'b0, REG_STAT, 32'h0000_0000);
      chk("stat_on", rd[5:0], seed[5:0]);
      chk("drive", drv, seed[5:0]);
    end
    xfer(1'b1, REG_CMD, 32'h0000_003F);
    xfer(1'b1, REG_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk("global_output_disable", drv, 6'h00);
    xfer(1'b1, REG_CTRL, 32'h0000_0000);
    dev_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("dev_rst", drv, 6'h00);
    dev_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("resume", drv, 6'h3F);
    $display("test command done");
    for (int k = 0; k < 2; k++) begin
      mode[5:4] <= FC_SHORT_BAT;
      t0 = cyc;
      while (foff[2] !== 1'b1 && cyc < t0 + 2000) @(posedge clk_i);
      chk("ocur_time", (cyc - t0) inside {[400:1000]}, 1'b1);
      repeat (2) @(posedge clk_i);
      chk("trip_off", {foff, drv}, 12'h13B);
      mode[5:4] <= FC_OK;
      if (k == 0) begin
        xfer(1'b0, REG_DIAG, 32'h0000_0000);
        chk("ocur_code", rd[5:4], FC_SHORT_BAT);
      end else begin
        xfer(1'b1, REG_CMD, 32'h0000_003B);
        xfer(1'b1, REG_CMD, 32'h0000_003F);
      end
      repeat (3) @(posedge clk_i);
      chk("restart", drv, 6'h3F);
    end
    xfer(1'b0, REG_DIAG, 32'h0000_0000);
    chk("latched", rd[5:4], FC_SHORT_BAT);
    xfer(1'b0, REG_DIAG, 32'h0000_0000);
    chk("cleared", rd, 32'h0000_0FFF);
    $display("test overcurrent done");
    mode[9:8] <= FC_SHORT_GND;
    xfer(1'b1, REG_CMD, 32'h0000_002F);
    repeat (40) @(posedge clk_i);
    xfer(1'b0, REG_DIAG, 32'h0000_0000);
    chk("blank", rd[9:8], FC_OK);
    repeat (60) @(posedge clk_i);
    xfer(1'b0, REG_DIAG, 32'h0000_0000);
    chk("gnd", rd[9:8], exp_off(FC_SHORT_GND));
    repeat (5) @(posedge clk_i);
    mode[9:8] <= FC_OPEN;
    repeat (60) @(posedge clk_i);
    xfer(1'b0, REG_DIAG, 32'h0000_0000);
    chk("first_kept", rd[9:8], FC_SHORT_GND);
    repeat (60) @(posedge clk_i);
    xfer(1'b0, REG_DIAG, 32'h0000_0000);
    chk("open", rd[9:8], exp_off(FC_OPEN));
    $display("test offstate done");
    mode <= 12'hFFF;
    xfer(1'b1, REG_CMD, 32'h0000_003F);
    xfer(1'b1, REG_CONF7, 32'h0000_0003);
    bat_low <= 1'b1;
    dev_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("hold_run", {hact, drv}, 8'hC3);
    xfer(1'b0, REG_STAT, 32'h0000_0000);
    chk("stat_run", rd[9:0], 10'h0C3);
    repeat (50) @(posedge clk_i);
    dev_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("takeover", {hact, drv}, 8'h3F);
    xfer(1'b1, REG_CONF7, 32'h0000_0001);
    dev_n <= 1'b0;
    repeat (HC - 10) @(posedge clk_i);
    chk("hold_on", {hact, drv}, 8'h41);
    repeat (15) @(posedge clk_i);
    chk("expired", {hact, drv}, 8'h00);
    xfer(1'b0, REG_STAT, 32'h0000_0000);
    chk("stat_exp", rd[9:0], 10'h100);
    xfer(1'b0, REG_CMD, 32'h0000_0000);
    chk("cmd_clr", rd, 32'h0000_003E);
    dev_n <= 1'b1;
    xfer(1'b1, REG_CMD, 32'h0000_003F);
    bat_low <= 1'b0;
    dev_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("no_lowbat", {hact, drv}, 8'h00);
    dev_n <= 1'b1;
    $display("test hold done");
    final_report();
  end
endmodule : tb
bind rld_top rld_properties #(.DIAG_FILT_CYC(DIAG_FILT_CYC), .BLANK_CYC(BLANK_CYC),
  .HOLD_CYC(HOLD_CYC)) i_rld_properties (.clk_i(clk_i), .reset_i(reset_i),
  .device_reset_signal_n_i(device_reset_signal_n_i),
  .battery_low_level_i(battery_low_level_i), .overcurrent_fault_i(overcurrent_fault_i),
  .drive_on_o(drive_on_o), .fast_off_o(fast_off_o), .hold_active_o(hold_active_o));
